// File: src/ppc_port.sv
// Eight-pin port: configuration registers, drive control, edge interrupts
//
// Summary of operation
// - Three-bit drive mode per pin, independent
// - Codes 0-3 per drive table
// - Codes 4-7 per drive table
// - Reset gives analog high-Z, input off
// - Digital high-Z: driver off, input on
// - Regulated special pins lose resistive modes
// - Output from register or routed signal
// - Port form and pin form share storage
// - Routed enable toggles input versus drive
// - Sixteen routed enables, any to pins
// - Per-pin slew, strong and open-drain only
// - Eight pins feed one interrupt request
// - Edge select none, rise, fall, both
// - Selected edge sets flag, raises request
// - Edge logic runs regardless of sleep
// - Edge detection only, no levels
// - Port setting picks CMOS or LVTTL
// - Per-pin input disable blocks input path
// - Pin state reads pad, not output
// - Reset release loads stored reset config
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "ppc_params.svh"
module ppc_port import ppc_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [`PPC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Routed logic
    input wire logic [7:0] routed_out,
    input wire logic [15:0] routed_oe,
    output logic [7:0] routed_in,
    // Stored reset configuration
    input wire logic [1:0] nv_reset_cfg,
    // Pads
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_strong_hi,
    output logic [7:0] pad_strong_lo,
    output logic [7:0] pad_weak_hi,
    output logic [7:0] pad_weak_lo,
    output logic [7:0] pad_ibuf_en,
    output logic [7:0] pad_slow_slew,
    output logic pad_lvttl,
    // Interrupt
    output logic port_irq
);
    logic [7:0] out_value_r;
    logic [7:0] dm_lo_r;
    logic [7:0] dm_mid_r;
    logic [7:0] dm_hi_r;
    logic [7:0] bypass_r;
    logic [7:0] bidir_r;
    logic [7:0] slew_r;
    logic [7:0] ibuf_dis_r;
    logic [1:0] port_ctl_r;
    logic [7:0] special_r;
    logic [7:0] edge_lo_r;
    logic [7:0] edge_hi_r;
    logic [7:0] flags_r;
    logic [1:0] rst_cfg_r;
    logic [3:0] oe_sel_r [8];
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic [7:0] sync3_r;
    logic [7:0] state_r;
    logic [7:0] rdata_nxt;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] hit;
    logic [7:0] ibuf_cfg;
    logic load_cfg_r;
    logic apply_cfg_r;
    logic flag_read;

    wire wr_port = reg_wr && clk_en;
    // Pin form covers eight addresses only; the rest of the upper half reads 0
    wire pf_hit = (reg_addr[5:3] == 3'h4);
    wire [2:0] pf_pin = reg_addr[2:0];
    wire oe_hit = (reg_addr[5:4] == 2'h1);
    assign flag_read = reg_rd && clk_en
        && reg_addr == `PPC_OFS_IRQ_FLAGS;

    // Port-form and pin-form strobe for a bit vector register
    function automatic logic [7:0] pw(input logic [7:0] cur,
                                      input logic [`PPC_ADDR_W-1:0] ofs,
                                      input integer pos);
        logic [7:0] v;
        v = cur;
        if (wr_port && reg_addr == ofs)
            v = reg_wdata;
        else if (wr_port && pf_hit)
            v[pf_pin] = reg_wdata[pos];
        return v;
    endfunction : pw

    // Configuration storage, one copy for both views
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_value_r <= 8'h00;
            dm_lo_r <= 8'h00;
            dm_mid_r <= 8'h00;
            dm_hi_r <= 8'h00;
            bypass_r <= 8'h00;
            bidir_r <= 8'h00;
            slew_r <= 8'h00;
            ibuf_dis_r <= 8'h00;
        end else if (clk_en) begin
            out_value_r <= pw(out_value_r, `PPC_OFS_OUT_VALUE,
                              `PPC_PF_OUT);
            dm_lo_r <= pw(dm_lo_r, `PPC_OFS_DM_LO, `PPC_PF_DM_LO);
            dm_mid_r <= pw(dm_mid_r, `PPC_OFS_DM_MID, `PPC_PF_DM_LO + 1);
            dm_hi_r <= pw(dm_hi_r, `PPC_OFS_DM_HI, `PPC_PF_DM_HI);
            bypass_r <= pw(bypass_r, `PPC_OFS_BYPASS, `PPC_PF_BYP);
            bidir_r <= pw(bidir_r, `PPC_OFS_BIDIR, `PPC_PF_BIE);
            slew_r <= pw(slew_r, `PPC_OFS_SLEW, `PPC_PF_SLW);
            ibuf_dis_r <= pw(ibuf_dis_r, `PPC_OFS_IBUF_DIS, `PPC_PF_IBD);
            // Reset-config pulls apply once after reset release
            if (apply_cfg_r) begin
                case (rst_cfg_r)
                    `PPC_RSTCFG_PULLDN: begin
                        dm_lo_r <= 8'hff;
                        dm_mid_r <= 8'hff;
                        out_value_r <= 8'h00;
                    end
                    `PPC_RSTCFG_PULLUP: begin
                        dm_mid_r <= 8'hff;
                        out_value_r <= 8'hff;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Port-level and misc settings
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            port_ctl_r <= 2'h0;
            special_r <= 8'h00;
            edge_lo_r <= 8'h00;
            edge_hi_r <= 8'h00;
        end else if (wr_port) begin
            case (reg_addr)
                `PPC_OFS_PORT_CTL: port_ctl_r <= reg_wdata[1:0];
                `PPC_OFS_SPECIAL: special_r <= reg_wdata;
                `PPC_OFS_EDGE_LO: edge_lo_r <= reg_wdata;
                `PPC_OFS_EDGE_HI: edge_hi_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Capture of the stored reset configuration after release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_cfg_r <= `PPC_RSTCFG_HIZ;
            load_cfg_r <= 1'b1;
            apply_cfg_r <= 1'b0;
        end else if (clk_en) begin
            load_cfg_r <= 1'b0;
            // Applied one edge after capture, once rst_cfg_r holds it
            apply_cfg_r <= load_cfg_r;
            if (load_cfg_r)
                rst_cfg_r <= nv_reset_cfg;
            else if (wr_port && reg_addr == `PPC_OFS_RST_CFG)
                rst_cfg_r <= reg_wdata[1:0];
        end
    end

    // Enable routing selects
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++)
                oe_sel_r[i] <= 4'h0;
        end else if (wr_port && oe_hit && !reg_addr[3]) begin
            oe_sel_r[reg_addr[2:0]] <= reg_wdata[3:0];
        end
    end

    // Pad synchroniser; only stages two and three are looked at
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
            sync3_r <= 8'h00;
            state_r <= 8'h00;
        end else if (clk_en) begin
            sync1_r <= pad_in & ibuf_cfg;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            for (int i = 0; i < 8; i++)
                if (sync2_r[i] == sync3_r[i])
                    state_r[i] <= sync3_r[i];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            logic [2:0] mode;
            logic drv_data;
            logic oe_on;
            logic [2:0] eff_mode;
            logic buf_on;
            logic s_hi;
            logic s_lo;
            assign mode = {dm_hi_r[g], dm_mid_r[g], dm_lo_r[g]};
            assign drv_data = bypass_r[g] ? routed_out[g]
                                          : out_value_r[g];
            assign oe_on = routed_oe[oe_sel_r[g]];
            // Enable low falls back to digital input
            assign eff_mode = (bidir_r[g] && !oe_on)
                ? 3'(PPC_DM_HIZ_DIGITAL) : mode;

            ppc_pin_drive u_drive (
                .mode(eff_mode),
                .data(drv_data),
                .regulated(special_r[g] & port_ctl_r[`PPC_CTL_REGOUT]),
                .strong_hi(s_hi),
                .strong_lo(s_lo),
                .weak_hi(pad_weak_hi[g]),
                .weak_lo(pad_weak_lo[g]),
                .ibuf_on(buf_on)
            );
            assign pad_strong_hi[g] = s_hi;
            assign pad_strong_lo[g] = s_lo;
            assign ibuf_cfg[g] = buf_on & ~ibuf_dis_r[g];
            // Slow edges only matter when a strong leg is used
            assign pad_slow_slew[g] = ~slew_r[g]
                & eff_mode[2] & ~(eff_mode == 3'(PPC_DM_PULL_BOTH));

            // Edge-only detection on the filtered level
            assign rise[g] = sync3_r[g] & sync2_r[g] & ~state_r[g];
            assign fall[g] = ~sync3_r[g] & ~sync2_r[g] & state_r[g];
            always_comb begin
                case ({edge_hi_r[g], edge_lo_r[g]})
                    `PPC_EDGE_RISE: hit[g] = rise[g];
                    `PPC_EDGE_FALL: hit[g] = fall[g];
                    `PPC_EDGE_BOTH: hit[g] = rise[g] | fall[g];
                    default: hit[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    assign pad_ibuf_en = ibuf_cfg;
    assign pad_lvttl = port_ctl_r[`PPC_CTL_LVTTL];
    assign routed_in = state_r;

    // Flags: an edge in the clearing read's cycle survives
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            flags_r <= 8'h00;
        else if (clk_en)
            flags_r <= (flag_read ? 8'h00 : flags_r) | hit;
    end

    // One request for the port; no sleep gating exists here
    assign port_irq = |flags_r;

    always_comb begin
        rdata_nxt = 8'h00;
        if (pf_hit) begin
            rdata_nxt[`PPC_PF_OUT] = out_value_r[pf_pin];
            rdata_nxt[`PPC_PF_DM_LO] = dm_lo_r[pf_pin];
            rdata_nxt[`PPC_PF_DM_LO + 1] = dm_mid_r[pf_pin];
            rdata_nxt[`PPC_PF_DM_HI] = dm_hi_r[pf_pin];
            rdata_nxt[`PPC_PF_BYP] = bypass_r[pf_pin];
            rdata_nxt[`PPC_PF_BIE] = bidir_r[pf_pin];
            rdata_nxt[`PPC_PF_SLW] = slew_r[pf_pin];
            rdata_nxt[`PPC_PF_IBD] = ibuf_dis_r[pf_pin];
        end else if (oe_hit && !reg_addr[3]) begin
            rdata_nxt = {4'h0, oe_sel_r[reg_addr[2:0]]};
        end else begin
            case (reg_addr)
                `PPC_OFS_OUT_VALUE: rdata_nxt = out_value_r;
                `PPC_OFS_PIN_STATE: rdata_nxt = state_r;
                `PPC_OFS_DM_LO: rdata_nxt = dm_lo_r;
                `PPC_OFS_DM_MID: rdata_nxt = dm_mid_r;
                `PPC_OFS_DM_HI: rdata_nxt = dm_hi_r;
                `PPC_OFS_BYPASS: rdata_nxt = bypass_r;
                `PPC_OFS_BIDIR: rdata_nxt = bidir_r;
                `PPC_OFS_SLEW: rdata_nxt = slew_r;
                `PPC_OFS_IBUF_DIS: rdata_nxt = ibuf_dis_r;
                `PPC_OFS_PORT_CTL: rdata_nxt = {6'h00, port_ctl_r};
                `PPC_OFS_EDGE_LO: rdata_nxt = edge_lo_r;
                `PPC_OFS_EDGE_HI: rdata_nxt = edge_hi_r;
                `PPC_OFS_IRQ_FLAGS: rdata_nxt = flags_r;
                `PPC_OFS_SPECIAL: rdata_nxt = special_r;
                `PPC_OFS_RST_CFG: rdata_nxt = {6'h00, rst_cfg_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (clk_en && reg_rd)
            reg_rdata <= rdata_nxt;
        else if (clk_en)
            reg_rdata <= 8'h00;
    end
endmodule : ppc_port

// File: src/ppc_params.svh
// Register offsets, field positions and reset values of the port block
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH

`define PPC_ADDR_W 6
// Port form registers, one bit per pin except port control and reset configuration
`define PPC_OFS_OUT_VALUE 6'h00
`define PPC_OFS_PIN_STATE 6'h01
`define PPC_OFS_DM_LO 6'h02
`define PPC_OFS_DM_MID 6'h03
`define PPC_OFS_DM_HI 6'h04
`define PPC_OFS_BYPASS 6'h05
`define PPC_OFS_BIDIR 6'h06
`define PPC_OFS_SLEW 6'h07
`define PPC_OFS_IBUF_DIS 6'h08
`define PPC_OFS_PORT_CTL 6'h09
`define PPC_OFS_EDGE_LO 6'h0a
`define PPC_OFS_EDGE_HI 6'h0b
`define PPC_OFS_IRQ_FLAGS 6'h0c
`define PPC_OFS_SPECIAL 6'h0d
`define PPC_OFS_RST_CFG 6'h0e
// OE routing select per pin: 0x10 + pin, low four bits
`define PPC_OFS_OE_SEL 6'h10
// Pin form: 0x20 + pin
`define PPC_OFS_PIN_FORM 6'h20

// Pin form field positions
`define PPC_PF_OUT 0
`define PPC_PF_DM_LO 1
`define PPC_PF_DM_HI 3
`define PPC_PF_BYP 4
`define PPC_PF_BIE 5
`define PPC_PF_SLW 6
`define PPC_PF_IBD 7

// Port control fields
`define PPC_CTL_LVTTL 0
`define PPC_CTL_REGOUT 1

// Reset configuration codes
`define PPC_RSTCFG_HIZ 2'h0
`define PPC_RSTCFG_PULLDN 2'h1
`define PPC_RSTCFG_PULLUP 2'h2

`define PPC_DM_RESET 3'h0
`define PPC_EDGE_NONE 2'h0
`define PPC_EDGE_RISE 2'h1
`define PPC_EDGE_FALL 2'h2
`define PPC_EDGE_BOTH 2'h3

`endif

// File: src/ppc_pkg.sv
// Types shared by the port block
package ppc_pkg;
    typedef enum logic [2:0] {
        PPC_DM_HIZ_ANALOG,
        PPC_DM_HIZ_DIGITAL,
        PPC_DM_PULL_UP,
        PPC_DM_PULL_DOWN,
        PPC_DM_OD_LOW,
        PPC_DM_OD_HIGH,
        PPC_DM_STRONG,
        PPC_DM_PULL_BOTH
    } ppc_drive_t;
endpackage : ppc_pkg

// File: src/ppc_pin_drive.sv
// Per-pin drive decode: mode and data to pad controls
`timescale 1ns/100ps
`include "ppc_params.svh"
module ppc_pin_drive import ppc_pkg::*; (
    // Configuration
    input wire logic [2:0] mode,
    input wire logic data,
    input wire logic regulated,
    // Pad controls
    output logic strong_hi,
    output logic strong_lo,
    output logic weak_hi,
    output logic weak_lo,
    output logic ibuf_on
);
    ppc_drive_t dm;
    assign dm = ppc_drive_t'(mode);

    always_comb begin
        strong_hi = 1'b0;
        strong_lo = 1'b0;
        weak_hi = 1'b0;
        weak_lo = 1'b0;
        ibuf_on = 1'b1;
        case (dm)
            PPC_DM_HIZ_ANALOG: ibuf_on = 1'b0;
            PPC_DM_HIZ_DIGITAL: ibuf_on = 1'b1;
            PPC_DM_PULL_UP: begin
                weak_hi = data;
                strong_lo = ~data;
            end
            PPC_DM_PULL_DOWN: begin
                strong_hi = data;
                weak_lo = ~data;
            end
            PPC_DM_OD_LOW: strong_lo = ~data;
            PPC_DM_OD_HIGH: strong_hi = data;
            PPC_DM_STRONG: begin
                strong_hi = data;
                strong_lo = ~data;
            end
            PPC_DM_PULL_BOTH: begin
                weak_hi = data;
                weak_lo = ~data;
            end
            default: ibuf_on = 1'b0;
        endcase
        // Regulated output has no resistive legs
        if (regulated) begin
            weak_hi = 1'b0;
            weak_lo = 1'b0;
        end
    end
endmodule : ppc_pin_drive

// File: dv/ppc_port_props.sv
// Checker for the port block's pad, bus and interrupt ports
`timescale 1ns/100ps
`include "ppc_params.svh"
module ppc_port_props (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [`PPC_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pads and interrupt
    input wire logic [7:0] routed_in,
    input wire logic [7:0] pad_in,
    input wire logic [7:0] pad_strong_hi,
    input wire logic [7:0] pad_strong_lo,
    input wire logic [7:0] pad_weak_hi,
    input wire logic [7:0] pad_weak_lo,
    input wire logic [7:0] pad_slow_slew,
    input wire logic pad_lvttl,
    input wire logic port_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [2:0] calm_r;
    logic rd_flags;
    logic [7:0] any_weak;
    assign rd_flags = reg_rd && reg_addr == `PPC_OFS_IRQ_FLAGS;
    assign any_weak = pad_weak_hi | pad_weak_lo;
    // Quiet pads leave no edge pending in the synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) calm_r <= 3'h0;
        else if ($changed(pad_in)) calm_r <= 3'h0;
        else if (calm_r != 3'h7) calm_r <= calm_r + 3'h1;
    end
    sequence s_clear_read;
        rd_flags && calm_r == 3'h7;
    endsequence
    chk_flag_clear: assert property (s_clear_read |-> ##[1:2] !port_irq)
        else $error("request stays up after flag read");
    chk_irq_cause: assert property ($rose(port_irq) |-> calm_r < 3'h6)
        else $error("request rose without a pad edge");
    chk_irq_drop: assert property ($fell(port_irq) |->
        $past(rd_flags) || $past(rd_flags, 2))
        else $error("request fell without a flag read");
    chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    chk_pin_state: assert property (reg_rd && reg_addr == `PPC_OFS_PIN_STATE
        |=> reg_rdata == $past(routed_in))
        else $error("pin state read differs from pad levels");
    chk_no_fight: assert property ((pad_strong_hi & pad_strong_lo) == 8'h00
        && (pad_weak_hi & pad_weak_lo) == 8'h00)
        else $error("both legs of one kind on");
    chk_leg_single: assert property (
        ((pad_strong_hi | pad_strong_lo) & any_weak) == 8'h00)
        else $error("strong and weak legs on together");
    chk_slew_strong: assert property ((pad_slow_slew & any_weak) == 8'h00)
        else $error("slow slew in a resistive mode");
    chk_lvttl_write: assert property ($changed(pad_lvttl) |->
        $past(reg_wr && reg_addr == `PPC_OFS_PORT_CTL))
        else $error("threshold changed without a write");
endmodule : ppc_port_props

// File: dv/ppc_pad_model.sv
// Board circuitry on the eight pads
`timescale 1ns/100ps
module ppc_pad_model (
    // Clock
    input wire logic clock,
    // Drive legs from the port
    input wire logic [7:0] strong_hi,
    input wire logic [7:0] strong_lo,
    input wire logic [7:0] weak_hi,
    input wire logic [7:0] weak_lo,
    // Board driver
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    // Resolved level
    output logic [7:0] pad
);
    logic [7:0] act;
    logic [7:0] held = 8'h00;
    assign act = strong_hi | strong_lo | weak_hi | weak_lo | ext_en;
    // Undriven pads show the inverse of the last level, never a lucky match
    always @(posedge clock) held <= (held & ~act) | (pad & act);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (strong_hi[i] | strong_lo[i]) pad[i] = strong_hi[i];
            else if (ext_en[i]) pad[i] = ext_val[i];
            else if (weak_hi[i] | weak_lo[i]) pad[i] = weak_hi[i];
            else pad[i] = ~held[i];
        end
    end
endmodule : ppc_pad_model

// File: dv/ppc_port_bench.sv
// Self-checking bench for the eight-pin port
`timescale 1ns/100ps
`include "ppc_params.svh"
module ppc_port_bench;
    logic clock, rst_n, reg_wr, reg_rd, lvttl, irq;
    logic [`PPC_ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, routed_out, routed_in, pad_in, ext_val;
    logic [7:0] sh, sl, wh, wl, ibuf, slow;
    logic [15:0] routed_oe;
    int fail_count = 0;
    int checked = 0;
    // Legs {strong hi, strong lo, weak hi, weak lo} by {mode, data}
    logic [3:0] dt [16] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h2, 4'h1, 4'h8,
        4'h4, 4'h0, 4'h0, 4'h8, 4'h4, 4'h8, 4'h1, 4'h2};
    ppc_port dut_u (.clock, .rst_n, .clk_en(1'b1), .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .routed_out, .routed_oe, .routed_in,
        .nv_reset_cfg(`PPC_RSTCFG_PULLUP), .pad_in, .pad_strong_hi(sh),
        .pad_strong_lo(sl), .pad_weak_hi(wh), .pad_weak_lo(wl),
        .pad_ibuf_en(ibuf), .pad_slow_slew(slow), .pad_lvttl(lvttl),
        .port_irq(irq));
    ppc_pad_model pads_u (.clock, .strong_hi(sh), .strong_lo(sl),
        .weak_hi(wh), .weak_lo(wl), .ext_en(8'h01), .ext_val, .pad(pad_in));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    function automatic logic [7:0] legs0();
        return {4'h0, sh[0], sl[0], wh[0], wl[0]};
    endfunction : legs0
    task chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [5:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
        #1;
    endtask : wr
    task rd(input logic [5:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    task print_verdict();
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #40000;
        fail_count++;
        print_verdict();
    end
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {routed_out, routed_oe, ext_val} = '0;
        repeat (8) @(posedge clock);
        #1 chk(wh, 8'h00);
        chk(ibuf, 8'h00);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        #1 chk(wh, 8'hff);
        rd(6'h03, 8'hff);
        rd(6'h3f, 8'h00);
        for (int k = 0; k < 16; k++) begin
            wr(6'h20, 8'(k));
            chk(legs0(), {4'h0, dt[k]});
            chk(8'(ibuf[0]), 8'(k > 1));
            chk(8'(slow[0]), 8'(k > 7 && k < 14));
            rd(6'h03, 8'hfe | 8'(k[2]));
        end
        // Bypass takes the routed bit over the output register
        routed_out <= 8'h01;
        wr(6'h07, 8'h01);
        wr(6'h20, 8'h5c);
        chk(legs0(), 8'h08);
        chk(8'(slow[0]), 8'h00);
        wr(6'h10, 8'h05);
        wr(6'h20, 8'h2c);
        chk(legs0(), 8'h00);
        chk(8'(ibuf[0]), 8'h01);
        routed_oe <= 16'h0020;
        @(posedge clock);
        #1 chk(legs0(), 8'h04);
        routed_oe <= 16'h0000;
        ext_val <= 8'h01;
        wr(6'h20, 8'h82);
        chk(8'(ibuf[0]), 8'h00);
        repeat (4) @(posedge clock);
        rd(6'h01, 8'hfe);
        wr(6'h09, 8'h03);
        wr(6'h0d, 8'h01);
        wr(6'h20, 8'h05);
        chk(8'(lvttl), 8'h01);
        chk(legs0(), 8'h00);
        ext_val <= 8'h00;
        wr(6'h20, 8'h02);
        for (int c = 0; c < 4; c++) begin
            wr(6'h0a, 8'(c & 1));
            wr(6'h0b, 8'(c >> 1));
            ext_val <= 8'h01;
            repeat (8) @(posedge clock);
            #1 chk(8'(irq), 8'(c & 1));
            rd(6'h01, 8'hff);
            rd(6'h00, 8'hfe);
            rd(6'h0c, 8'(c & 1));
            rd(6'h0c, 8'h00);
            chk(8'(irq), 8'h00);
            ext_val <= 8'h00;
            repeat (8) @(posedge clock);
            rd(6'h0c, 8'(c >> 1));
        end
        print_verdict();
    end
endmodule : ppc_port_bench
bind ppc_port ppc_port_props chk_u (.clock, .rst_n, .reg_addr, .reg_wr,
    .reg_rd, .reg_rdata, .routed_in, .pad_in, .pad_strong_hi, .pad_strong_lo,
    .pad_weak_hi, .pad_weak_lo, .pad_slow_slew, .pad_lvttl, .port_irq);
